// ---- pkg/dac_port_cfg.svh ----
// Constants of the serial converter write port
`ifndef DAC_PORT_CFG_SVH
`define DAC_PORT_CFG_SVH

// ****************************************************************
// Word layout
// ****************************************************************
`define WORD_BITS      16
`define CTRL_HI_POS    15
`define CTRL_LO_POS    14
`define CODE_MSB       13
`define CODE_BITS_MAX  14

// ****************************************************************
// Control codes
// ****************************************************************
`define CTRL_LOAD      2'h0
`define CTRL_RSVD_A    2'h1
`define CTRL_RSVD_B    2'h2
`define CTRL_EDGE      2'h3

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define WORD_RESET     16'h0000
`define FIFO_DEPTH     8
`define SYNC_STAGES    2

`endif

// ---- pkg/dac_port_pkg.sv ----
// Types shared by the serial converter write port
package dac_port_pkg;
   // One received frame, control on top, code left-aligned below
   typedef struct packed {
      logic [1:0]  ctrl;
      logic [13:0] code;
   } frame_s;
endpackage

// ---- src/bit_sync.sv ----
// Two flip-flop level synchroniser
module bit_sync
   import dac_port_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         meta   <= '1;
         o_sync <= '1;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // bit_sync

// ---- src/frame_fifo.sv ----
// Flip-flop FIFO with valid and ready on both sides
module frame_fifo
   import dac_port_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_srst,
   input  wire logic [WIDTH-1:0] i_data,
   input  wire logic             i_valid,
   output logic                  o_ready,
   output logic      [WIDTH-1:0] o_data,
   output logic                  o_valid,
   input  wire logic             i_ready,
   output logic                  o_full
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_idx;
   logic [AW-1:0]    rd_idx;
   logic [AW:0]      count;
   wire              push = i_valid & o_ready;
   wire              pop  = o_valid & i_ready;

   // Flags follow the fill count
   assign o_ready = (count < (AW+1)'(DEPTH));
   assign o_full  = (count == (AW+1)'(DEPTH));
   assign o_valid = (count != '0);
   assign o_data  = mem[rd_idx];

   // Storage write
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_idx] <= i_data;
      end
   end

   // Pointers and count
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
         end
         if (pop) begin
            rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // frame_fifo

// ---- src/dac_serial_input_port.sv ----
// Serial write port of a multiplying current-output converter
`include "dac_port_cfg.svh"

module dac_serial_input_port
   import dac_port_pkg::*;
#(
   parameter int CODE_BITS  = `CODE_BITS_MAX,
   parameter int FIFO_WORDS = `FIFO_DEPTH
) (
   input  wire logic                 I_CORE_CLK,
   input  wire logic                 I_SRST,
   input  wire logic                 I_SCLK,
   input  wire logic                 I_FRAME_SYNC_N,
   input  wire logic                 I_SERIAL_DATA_IN,
   input  wire logic                 I_CONV_READY,
   output logic      [CODE_BITS-1:0] O_DAC_CODE,
   output logic                      O_CODE_UPDATE,
   output logic                      O_RISING_EDGE_MODE,
   output logic                      O_FRAME_LOST,
   output logic                      O_FIFO_FULL
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   logic [`WORD_BITS-1:0] shift_fall;
   logic [`WORD_BITS-1:0] shift_rise;
   logic                  link_clr;
   logic                  fs_sync;
   logic                  fs_prev;
   logic                  frame_done;
   logic                  rising_mode;
   frame_s                hold_word;
   logic                  hold_valid;
   frame_s                fifo_out;
   logic                  fifo_out_valid;
   logic                  fifo_in_ready;
   logic                  fifo_full;

   // ****************************************************************
   // Link clock domain
   // ****************************************************************

   // Link clear is a core flop so the idle link clock needs no edge
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         link_clr <= 1'b1;
      end else begin
         link_clr <= 1'b0;
      end
   end

   // Falling edge shifter, used until the edge is changed
   always_ff @(negedge I_SCLK or posedge link_clr) begin
      if (link_clr) begin
         shift_fall <= `WORD_RESET;
      end else if (!I_FRAME_SYNC_N) begin
         shift_fall <= {shift_fall[`WORD_BITS-2:0], I_SERIAL_DATA_IN};
      end
   end

   // Rising edge shifter, used once rising capture is selected
   always_ff @(posedge I_SCLK or posedge link_clr) begin
      if (link_clr) begin
         shift_rise <= `WORD_RESET;
      end else if (!I_FRAME_SYNC_N) begin
         shift_rise <= {shift_rise[`WORD_BITS-2:0], I_SERIAL_DATA_IN};
      end
   end

   // ****************************************************************
   // Frame end detection in the core domain
   // ****************************************************************

   // Frame sync pin crosses by two flops; resets to the idle high level
   bit_sync #(
      .WIDTH (1)
   ) u_fs_sync (
      .i_clk   (I_CORE_CLK),
      .i_srst  (I_SRST),
      .i_async (I_FRAME_SYNC_N),
      .o_sync  (fs_sync)
   );

   // Rising edge of the synchronised frame sync closes a frame
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         fs_prev    <= 1'b1;
         frame_done <= 1'b0;
      end else begin
         fs_prev    <= fs_sync;
         frame_done <= fs_sync & ~fs_prev;
      end
   end

   // ****************************************************************
   // Word selection and decode
   // ****************************************************************

   // Shifters are frozen while frame sync is high, so reading them here is safe
   wire [`WORD_BITS-1:0] sel_raw   = rising_mode ? shift_rise : shift_fall;
   wire frame_s          sel_word  = frame_s'(sel_raw);
   wire [1:0]            sel_ctrl  = {sel_raw[`CTRL_HI_POS], sel_raw[`CTRL_LO_POS]};
   wire                  is_load   = (sel_ctrl == `CTRL_LOAD);
   wire                  is_edge   = (sel_ctrl == `CTRL_EDGE);
   wire                  take_load = frame_done & is_load;
   wire                  take_edge = frame_done & is_edge;
   wire                  hold_push = hold_valid & fifo_in_ready;
   wire                  lost      = take_load & hold_valid & ~fifo_in_ready;

   // Code of the head entry, low bits dropped for narrow variants
   wire [CODE_BITS-1:0]  out_code  = fifo_out.code[`CODE_MSB -: CODE_BITS];
   wire                  conv_take = fifo_out_valid & I_CONV_READY;

   // ****************************************************************
   // Capture edge mode
   // ****************************************************************

   // Sticky until reset; no control value clears it
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         rising_mode <= 1'b0;
      end else if (take_edge) begin
         rising_mode <= 1'b1;
      end
   end

   // ****************************************************************
   // Holding register ahead of the FIFO
   // ****************************************************************

   // Only load frames are kept; edge and reserved frames leave output alone
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         hold_valid <= 1'b0;
         hold_word  <= frame_s'(`WORD_RESET);
      end else if (take_load && (!hold_valid || fifo_in_ready)) begin
         hold_valid <= 1'b1;
         hold_word  <= sel_word;
      end else if (hold_push) begin
         hold_valid <= 1'b0;
      end
   end

   // ****************************************************************
   // Frame buffer
   // ****************************************************************

   frame_fifo #(
      .WIDTH ($bits(frame_s)),
      .DEPTH (FIFO_WORDS)
   ) u_fifo (
      .i_clk   (I_CORE_CLK),
      .i_srst  (I_SRST),
      .i_data  (hold_word),
      .i_valid (hold_valid),
      .o_ready (fifo_in_ready),
      .o_data  (fifo_out),
      .o_valid (fifo_out_valid),
      .i_ready (I_CONV_READY),
      .o_full  (fifo_full)
   );

   // ****************************************************************
   // Converter register and status outputs
   // ****************************************************************

   // Converter register loads when the core accepts the head word
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_DAC_CODE    <= '0;
         O_CODE_UPDATE <= 1'b0;
      end else begin
         O_CODE_UPDATE <= conv_take;
         if (conv_take) begin
            O_DAC_CODE <= out_code;
         end
      end
   end

   // Status flags mirrored from internal state
   always_ff @(posedge I_CORE_CLK) begin
      if (I_SRST) begin
         O_RISING_EDGE_MODE <= 1'b0;
         O_FRAME_LOST       <= 1'b0;
         O_FIFO_FULL        <= 1'b0;
      end else begin
         O_RISING_EDGE_MODE <= rising_mode | take_edge;
         O_FRAME_LOST       <= lost;
         O_FIFO_FULL        <= fifo_full;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************

   // Rising capture never reverts without reset
   property p_mode_sticky;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      rising_mode |=> rising_mode;
   endproperty
   a_mode_sticky: assert property (p_mode_sticky)
      else $error("capture edge reverted without reset");

   // An edge frame selects rising capture on the next cycle
   property p_mode_set;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      take_edge |=> rising_mode ##1 O_RISING_EDGE_MODE;
   endproperty
   a_mode_set: assert property (p_mode_set)
      else $error("edge frame did not select rising capture");

   // Rising capture appears only after an edge frame
   property p_mode_cause;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      $rose(rising_mode) |-> $past(frame_done) && $past(sel_ctrl) == `CTRL_EDGE;
   endproperty
   a_mode_cause: assert property (p_mode_cause)
      else $error("rising capture without an edge frame");

   // A load frame reaches the holding register with its word
   property p_load;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      take_load && !hold_valid |=> hold_valid && hold_word == $past(sel_word);
   endproperty
   a_load: assert property (p_load)
      else $error("load frame not captured");

   // Edge or reserved frames never enter the buffer
   property p_no_update;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      frame_done && !is_load && !hold_valid |=> !hold_valid;
   endproperty
   a_no_update: assert property (p_no_update)
      else $error("non-load frame was buffered");

   // One frame end per rising edge of frame sync
   property p_frame_once;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      frame_done |=> !frame_done;
   endproperty
   a_frame_once: assert property (p_frame_once)
      else $error("frame end reported twice");

   // A stalled holding word stays put
   property p_hold_stall;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      hold_valid && !fifo_in_ready |=> hold_valid && $stable(hold_word);
   endproperty
   a_hold_stall: assert property (p_hold_stall)
      else $error("held word changed under back-pressure");

   // Converter register takes the left-aligned code of the head word
   property p_update;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      conv_take |=> O_CODE_UPDATE && O_DAC_CODE == $past(out_code);
   endproperty
   a_update: assert property (p_update)
      else $error("converter register not updated from head word");

   // Outputs sit at zero scale right after reset
   property p_reset_zero;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      $fell(I_SRST) |-> O_DAC_CODE == '0 && !O_RISING_EDGE_MODE && !O_CODE_UPDATE;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("outputs not at zero scale after reset");

   // A dropped load frame is reported on the next cycle
   property p_lost_flag;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      lost |=> O_FRAME_LOST;
   endproperty
   a_lost_flag: assert property (p_lost_flag)
      else $error("dropped frame not reported");

   // Every update pulse follows a taken head word
   property p_update_cause;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      O_CODE_UPDATE |-> $past(conv_take);
   endproperty
   a_update_cause: assert property (p_update_cause)
      else $error("update pulse without a taken word");

   // Reserved control values leave the capture edge alone
   property p_reserved_ignored;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      frame_done && !is_load && !is_edge |=> rising_mode == $past(rising_mode);
   endproperty
   a_reserved_ignored: assert property (p_reserved_ignored)
      else $error("reserved control changed the capture edge");

   // Full flag follows the buffer one cycle later
   property p_full_flag;
      @(posedge I_CORE_CLK) disable iff (I_SRST)
      fifo_full |=> O_FIFO_FULL;
   endproperty
   a_full_flag: assert property (p_full_flag)
      else $error("full flag not raised");

endmodule // dac_serial_input_port

// ---- tb/host_link_model.sv ----
// Host side driver of the converter serial link
module host_link_model (
   output logic o_sclk,
   output logic o_sync_n,
   output logic o_data
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Idle link: clock still, frame sync high
   // ****************************************************************
   initial begin
      o_sclk   = 1'b0;
      o_sync_n = 1'b1;
      o_data   = 1'b0;
   end

   // One frame, MSB first, 160 ns bit time; data is right only at the capture edge
   task automatic send(input logic [31:0] word, input int nbits, input logic rising);
      logic b;
      o_sync_n = 1'b0;
      #40;
      for (int i = nbits - 1; i >= 0; i--) begin
         b = word[i];
         o_data = rising ? b : ~b;
         #40 o_sclk = 1'b1;
         #40 o_data = rising ? ~b : b;
         #40 o_sclk = 1'b0;
         #40;
      end
      o_sync_n = 1'b1;
      o_data   = ~o_data; // Released line shows no stale value
      #250;
   endtask
endmodule // host_link_model

// ---- tb/testbench.sv ----
// Self-checking bench of the converter serial write port
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // Signals and instances
   // ****************************************************************
   localparam int TIMEOUT = 20000;
   logic        core_clk = 1'b0;
   logic        srst = 1'b1;
   logic        conv_ready = 1'b1;
   wire         sclk;
   wire         sync_n;
   wire         sdata;
   logic [13:0] dac_code;
   logic [7:0]  code8;
   logic        code_update;
   logic        rise_mode;
   logic        frame_lost;
   logic        fifo_full;
   logic [13:0] upd_q[$];
   int          lost = 0;
   int          cycles = 0;
   int          miscompares = 0;
   int          samples_checked = 0;

   // Core clock, 25 ns period
   always #12.5 core_clk = ~core_clk;

   host_link_model host (.o_sclk(sclk), .o_sync_n(sync_n), .o_data(sdata));

   dac_serial_input_port #(.CODE_BITS(14), .FIFO_WORDS(8)) dut (
      .I_CORE_CLK(core_clk), .I_SRST(srst), .I_SCLK(sclk), .I_FRAME_SYNC_N(sync_n),
      .I_SERIAL_DATA_IN(sdata), .I_CONV_READY(conv_ready), .O_DAC_CODE(dac_code),
      .O_CODE_UPDATE(code_update), .O_RISING_EDGE_MODE(rise_mode), .O_FRAME_LOST(frame_lost),
      .O_FIFO_FULL(fifo_full));

   // Narrow variant keeps only the top eight code bits
   dac_serial_input_port #(.CODE_BITS(8), .FIFO_WORDS(8)) dut_8 (
      .I_CORE_CLK(core_clk), .I_SRST(srst), .I_SCLK(sclk), .I_FRAME_SYNC_N(sync_n),
      .I_SERIAL_DATA_IN(sdata), .I_CONV_READY(conv_ready), .O_DAC_CODE(code8),
      .O_CODE_UPDATE(), .O_RISING_EDGE_MODE(), .O_FRAME_LOST(), .O_FIFO_FULL());

   // Records every code update and dropped frame, and cuts a hang short
   always @(negedge core_clk) begin
      cycles++;
      if (code_update === 1'b1) upd_q.push_back(dac_code);
      if (frame_lost === 1'b1) lost++;
      if (cycles >= TIMEOUT) begin
         miscompares++;
         conclude();
      end
   end

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic conclude();
      $display("compared %0d, mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic expect_code(input logic [15:0] w);
      for (int i = 0; i < 400 && upd_q.size() < 1; i++) @(negedge core_clk);
      `CHK(upd_q.size(), 1)
      if (upd_q.size() > 0) `CHK(upd_q.pop_front(), w[13:0])
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      `CHK(dac_code, 14'h0000)
      `CHK(code8, 8'h00)
      `CHK(rise_mode, 1'b0)
      $display("test reset done");
   endtask

   task automatic t_long();
      host.send(32'h000f2c35, 20, 1'b0);
      expect_code(16'h2c35);
      `CHK(code8, 8'hb0)
      $display("test long frame done");
   endtask

   task automatic t_load();
      host.send(32'h00003fff, 16, 1'b0);
      expect_code(16'h3fff);
      `CHK(code8, 8'hff)
      $display("test full scale done");
   endtask

   // Twelve bits after 3fff leave control 11 in the register
   task automatic t_short();
      host.send(32'h00000320, 12, 1'b0);
      idle(20);
      `CHK(rise_mode, 1'b1)
      `CHK(upd_q.size(), 0)
      `CHK(dac_code, 14'h3fff)
      $display("test short frame done");
   endtask

   task automatic t_reserved();
      host.send(32'h00005555, 16, 1'b1);
      host.send(32'h00009555, 16, 1'b1);
      idle(20);
      `CHK(upd_q.size(), 0)
      `CHK(dac_code, 14'h3fff)
      $display("test reserved done");
   endtask

   // Data is only right at the rising edge now
   task automatic t_rising();
      host.send(32'h00002abc, 16, 1'b1);
      expect_code(16'h2abc);
      host.send(32'h0000c000, 16, 1'b1);
      host.send(32'h00001555, 16, 1'b1);
      expect_code(16'h1555);
      `CHK(rise_mode, 1'b1)
      `CHK(code8, 8'h55)
      $display("test rising edge done");
   endtask

   // Core stalls: hold plus eight words fill, the tenth frame is dropped
   task automatic t_fifo();
      @(negedge core_clk);
      conv_ready = 1'b0;
      for (int i = 0; i < 10; i++) host.send(32'h00000100 + i, 16, 1'b1);
      idle(10);
      `CHK(lost, 1)
      `CHK(fifo_full, 1'b1)
      `CHK(upd_q.size(), 0)
      conv_ready = 1'b1;
      idle(30);
      `CHK(upd_q.size(), 9)
      for (int i = 0; i < 9 && upd_q.size() > 0; i++) `CHK(upd_q.pop_front(), 14'h0100 + 14'(i))
      `CHK(fifo_full, 1'b0)
      $display("test buffering done");
   endtask

   // Second reset returns to falling capture and zero scale
   task automatic t_mid_reset();
      @(negedge core_clk);
      srst = 1'b1;
      idle(2);
      srst = 1'b0;
      idle(2);
      upd_q.delete();
      `CHK(dac_code, 14'h0000)
      `CHK(rise_mode, 1'b0)
      host.send(32'h00000aaa, 16, 1'b0);
      expect_code(16'h0aaa);
      $display("test second reset done");
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      idle(2);
      srst = 1'b0;
      idle(2);
      t_reset();
      t_long();
      t_load();
      t_short();
      t_reserved();
      t_rising();
      t_fifo();
      t_mid_reset();
      conclude();
   end
endmodule // testbench
